// file: rtl/shs_pkg.sv
package shs_pkg;

  // ---------------------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SHS_RUN       = 3'b000,
    SHS_HALT      = 3'b001,
    SHS_STOP      = 3'b010,
    SHS_STAB_WAIT = 3'b011,
    SHS_INT_WAIT  = 3'b100
  } shs_state_t;

  // ---------------------------------------------------------------------------
  // Wait select codes and reset values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SEL_2P11    = 3'h1;
  localparam logic [2:0] SEL_2P13    = 3'h2;
  localparam logic [2:0] SEL_2P14    = 3'h3;
  localparam logic [2:0] SEL_2P15    = 3'h4;
  localparam logic [2:0] SEL_2P16    = 3'h5;
  localparam logic [2:0] SEL_RESET   = 3'h5;
  localparam logic [4:0] STATUS_ZERO = 5'h00;

  // ---------------------------------------------------------------------------
  // Status bit positions, shortest threshold at bit 4
  // ---------------------------------------------------------------------------
  localparam int unsigned POS_2P11 = 4;
  localparam int unsigned POS_2P13 = 3;
  localparam int unsigned POS_2P14 = 2;
  localparam int unsigned POS_2P15 = 1;
  localparam int unsigned POS_2P16 = 0;

  // ---------------------------------------------------------------------------
  // Counts in high-speed clock periods and internal oscillator periods
  // ---------------------------------------------------------------------------
  localparam logic [16:0] CNT_2P11 = 17'h00800;
  localparam logic [16:0] CNT_2P13 = 17'h02000;
  localparam logic [16:0] CNT_2P14 = 17'h04000;
  localparam logic [16:0] CNT_2P15 = 17'h08000;
  localparam logic [16:0] CNT_2P16 = 17'h10000;
  localparam logic [4:0]  INT_OSC_RESUME_PERIODS = 5'h11;

  // Clock source selections seen at standby entry
  typedef struct packed {
    logic main_clock_select_bit;
    logic on_subsystem;
  } shs_clk_sel_t;

endpackage : shs_pkg

// file: rtl/shs_standby_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// (R1) Halt gates CPU clock only; running oscillators keep oscillating.
// (R2) Pending interrupt ends halt immediately with no stabilization wait.
// (R3) Stop instruction stops the high-speed oscillator.
// (R4) Interrupt releases stop; wait covers stabilization before CPU resumes on high-speed.
// (R5) Registers, flags and memory are held during standby.
// (R6) Port output latches and buffers are held during standby.
// (R7) Software enters stop only on high-speed or internal clock.
// (R8) Stop on internal clock leaves the internal oscillator running.
// (R9) On internal clock, CPU stays suspended 17 internal periods after stop release.
// (R10) Software stops peripherals before stop.
// (R11) Software should clear converter run bit before halt or stop.
// (R12) Halt keeps prescaler clock from CPU clock selected at halt entry.
// (R13) Internal oscillator stop bit obeyed only when option byte allows.
// (R14) Wait select 3 bits, reset 05H, codes choose 2^11 to 2^16 periods.
// (R15) Status bits set in order from shortest threshold and stay set.
// (R16) Reset, stop, or high-speed stop bits clear the status to zero.
// (R17) Wake on pending unmasked interrupt; entry after the instruction completes.
module shs_standby_ctrl (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // CPU side
  input  wire logic                 halt_insn_done,
  input  wire logic                 stop_insn_done,
  input  wire logic                 irq_pending_unmasked,
  output logic                      cpu_clk_en,
  output logic                      hold_state,
  output logic                      standby_active,
  // Clock generator side
  input  wire shs_pkg::shs_clk_sel_t clk_sel,
  input  wire logic                 main_osc_stop_bit,
  input  wire logic                 main_clock_halt_ctrl_bit,
  input  wire logic                 internal_osc_stop_bit,
  input  wire logic                 opt_int_osc_stoppable,
  input  wire logic                 hs_clk_tick,
  input  wire logic                 int_osc_tick,
  output logic                      main_osc_run,
  output logic                      int_osc_run,
  output logic                      periph_clk_sel,
  // Stabilization registers
  input  wire logic                 wait_sel_we,
  input  wire logic [2:0]           wait_sel_wdata,
  output logic [2:0]                stabilization_wait_select,
  output logic [4:0]                stabilization_status
);

  // ---------------------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------------------
  function automatic logic [16:0] wait_count(input logic [2:0] sel);
    case (sel)
      shs_pkg::SEL_2P11: wait_count = shs_pkg::CNT_2P11;
      shs_pkg::SEL_2P13: wait_count = shs_pkg::CNT_2P13;
      shs_pkg::SEL_2P14: wait_count = shs_pkg::CNT_2P14;
      shs_pkg::SEL_2P15: wait_count = shs_pkg::CNT_2P15;
      default:           wait_count = shs_pkg::CNT_2P16;
    endcase
  endfunction : wait_count

  shs_pkg::shs_state_t state_reg;
  shs_pkg::shs_state_t state_next;
  logic [16:0]         stab_cnt_reg;
  logic [4:0]          rc_cnt_reg;
  logic                sel_at_entry_reg;
  logic [2:0]          wait_sel_reg;
  logic [4:0]          status_reg;
  logic                counting;
  logic                status_clear;

  assign counting = (state_reg == shs_pkg::SHS_STAB_WAIT) ||
                    (state_reg == shs_pkg::SHS_INT_WAIT);
  // A clear also restarts the count, else a stale count sets the bits again
  assign status_clear = ((state_reg == shs_pkg::SHS_RUN) && stop_insn_done &&
                         !clk_sel.on_subsystem) ||
                        main_osc_stop_bit || main_clock_halt_ctrl_bit; // R16

  // ---------------------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      shs_pkg::SHS_RUN: begin
        if (stop_insn_done && !clk_sel.on_subsystem) begin
          state_next = shs_pkg::SHS_STOP; // R3 R7 R17
        end else if (halt_insn_done) begin
          state_next = shs_pkg::SHS_HALT; // R1 R17
        end
      end
      shs_pkg::SHS_HALT: begin
        if (irq_pending_unmasked) begin
          state_next = shs_pkg::SHS_RUN; // R2
        end
      end
      shs_pkg::SHS_STOP: begin
        if (irq_pending_unmasked) begin
          state_next = sel_at_entry_reg ? shs_pkg::SHS_STAB_WAIT
                                        : shs_pkg::SHS_INT_WAIT; // R4 R9
        end
      end
      shs_pkg::SHS_STAB_WAIT: begin
        if (hs_clk_tick && (stab_cnt_reg == wait_count(wait_sel_reg) - 17'h00001)) begin
          state_next = shs_pkg::SHS_RUN; // R4
        end
      end
      shs_pkg::SHS_INT_WAIT: begin
        if (int_osc_tick &&
            (rc_cnt_reg == shs_pkg::INT_OSC_RESUME_PERIODS - 5'h01)) begin
          state_next = shs_pkg::SHS_RUN; // R9
        end
      end
      default: state_next = shs_pkg::SHS_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= shs_pkg::SHS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Clock source captured at entry, so peripherals keep the same prescaler source
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_at_entry_reg <= 1'b0;
    end else if ((state_reg == shs_pkg::SHS_RUN) && (halt_insn_done || stop_insn_done)) begin
      sel_at_entry_reg <= clk_sel.main_clock_select_bit; // R12
    end
  end

  // ---------------------------------------------------------------------------
  // Stabilization counters
  // ---------------------------------------------------------------------------
  // The high-speed counter also runs after an internal-clock stop release, so status
  // still reflects the elapsed oscillation time; it stops at the selected wait.
  logic hs_counting_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hs_counting_reg <= 1'b0;
      stab_cnt_reg    <= 17'h00000;
    end else if (state_reg == shs_pkg::SHS_STOP) begin
      hs_counting_reg <= irq_pending_unmasked;
      stab_cnt_reg    <= 17'h00000;
    end else if (status_clear) begin
      stab_cnt_reg <= 17'h00000; // R16
    end else if (hs_counting_reg && hs_clk_tick) begin
      stab_cnt_reg <= stab_cnt_reg + 17'h00001; // R4
      if (stab_cnt_reg == wait_count(wait_sel_reg) - 17'h00001) begin
        hs_counting_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rc_cnt_reg <= 5'h00;
    end else if (state_reg != shs_pkg::SHS_INT_WAIT) begin
      rc_cnt_reg <= 5'h00;
    end else if (int_osc_tick) begin
      rc_cnt_reg <= rc_cnt_reg + 5'h01; // R9
    end
  end

  // ---------------------------------------------------------------------------
  // Wait select and status registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_sel_reg <= shs_pkg::SEL_RESET; // R14
    end else if (wait_sel_we) begin
      wait_sel_reg <= wait_sel_wdata; // R14
    end
  end

  // Reaching a count of 2^n sets that bit; shorter-threshold bits already set, so order holds
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_reg <= shs_pkg::STATUS_ZERO; // R16
    end else if (status_clear) begin
      status_reg <= shs_pkg::STATUS_ZERO; // R16
    end else begin
      if (stab_cnt_reg >= shs_pkg::CNT_2P11) status_reg[shs_pkg::POS_2P11] <= 1'b1; // R15
      if (stab_cnt_reg >= shs_pkg::CNT_2P13) status_reg[shs_pkg::POS_2P13] <= 1'b1; // R15
      if (stab_cnt_reg >= shs_pkg::CNT_2P14) status_reg[shs_pkg::POS_2P14] <= 1'b1; // R15
      if (stab_cnt_reg >= shs_pkg::CNT_2P15) status_reg[shs_pkg::POS_2P15] <= 1'b1; // R15
      if (stab_cnt_reg >= shs_pkg::CNT_2P16) status_reg[shs_pkg::POS_2P16] <= 1'b1; // R15
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign cpu_clk_en     = (state_reg == shs_pkg::SHS_RUN); // R1 R9
  assign standby_active = (state_reg != shs_pkg::SHS_RUN);
  assign hold_state     = standby_active; // R5 R6
  assign main_osc_run   = !main_osc_stop_bit &&
                          (state_reg != shs_pkg::SHS_STOP); // R3 R8
  assign int_osc_run    = !(internal_osc_stop_bit && opt_int_osc_stoppable); // R13 R8
  assign periph_clk_sel = standby_active ? sel_at_entry_reg
                                         : clk_sel.main_clock_select_bit; // R12
  assign stabilization_wait_select = wait_sel_reg;
  assign stabilization_status      = status_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  halt_wake_fast_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    (state_reg == shs_pkg::SHS_HALT) && irq_pending_unmasked |=> cpu_clk_en)
    else $error("halt not released in one cycle");

  halt_osc_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    (state_reg == shs_pkg::SHS_HALT) && !main_osc_stop_bit |-> main_osc_run && !cpu_clk_en)
    else $error("halt stopped oscillator or left cpu clock");

  stop_osc_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    (state_reg == shs_pkg::SHS_RUN) && stop_insn_done && !clk_sel.on_subsystem
    |=> !main_osc_run && !cpu_clk_en)
    else $error("stop did not stop oscillator");

  stop_wait_held_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
    (state_reg == shs_pkg::SHS_STOP) && irq_pending_unmasked && sel_at_entry_reg
    |=> !cpu_clk_en [*8])
    else $error("cpu resumed before stabilization");

  rc_suspend_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    (state_reg == shs_pkg::SHS_INT_WAIT) && !cpu_clk_en |-> rc_cnt_reg <= 5'h11)
    else $error("internal wait overran");

  int_osc_opt_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    !opt_int_osc_stoppable |-> int_osc_run)
    else $error("internal oscillator stopped without option");

  sel_reset_a: assert property (@(posedge clk_sys) // R14
    $rose(resetn) |-> stabilization_wait_select == shs_pkg::SEL_RESET)
    else $error("wait select reset value wrong");

  status_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    !main_osc_stop_bit && !main_clock_halt_ctrl_bit && !stop_insn_done
    |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
    else $error("status bit fell");

  status_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    main_osc_stop_bit |=> stabilization_status == 5'h00)
    else $error("status not cleared");

  periph_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    (state_reg == shs_pkg::SHS_HALT) |-> periph_clk_sel == sel_at_entry_reg)
    else $error("peripheral clock source changed in halt");

  wait_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4 R9
    counting |-> standby_active && !cpu_clk_en)
    else $error("cpu clock ran during a wake wait");

  hold_standby_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R5 R6
    standby_active |-> hold_state && !cpu_clk_en)
    else $error("state not held in standby");

  halt_entry_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R1 R17
    (state_reg == shs_pkg::SHS_RUN) && halt_insn_done && !stop_insn_done
    |=> standby_active && !cpu_clk_en)
    else $error("halt not entered after the instruction");

  sub_stop_ignore_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    (state_reg == shs_pkg::SHS_RUN) && stop_insn_done && clk_sel.on_subsystem &&
    !halt_insn_done |=> cpu_clk_en)
    else $error("stop taken on subsystem clock");

  stab_early_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
    (state_reg == shs_pkg::SHS_STAB_WAIT)
    |-> hs_counting_reg && (stab_cnt_reg < wait_count(wait_sel_reg)))
    else $error("stabilization count idle or past its end");

  stab_exit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
    (state_reg == shs_pkg::SHS_STAB_WAIT) && hs_clk_tick &&
    (stab_cnt_reg == wait_count(wait_sel_reg) - 17'h00001) |=> cpu_clk_en)
    else $error("cpu not resumed at end of wait");

  int_exit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    (state_reg == shs_pkg::SHS_INT_WAIT) && int_osc_tick &&
    (rc_cnt_reg == shs_pkg::INT_OSC_RESUME_PERIODS - 5'h01) |=> cpu_clk_en)
    else $error("cpu not resumed after internal wait");

  int_osc_stay_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
    (state_reg == shs_pkg::SHS_STOP) && !sel_at_entry_reg && !internal_osc_stop_bit
    |-> int_osc_run && !main_osc_run)
    else $error("internal stop changed the wrong oscillator");

  stop_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    (state_reg == shs_pkg::SHS_RUN) && stop_insn_done && !clk_sel.on_subsystem
    |=> stabilization_status == shs_pkg::STATUS_ZERO)
    else $error("status not cleared by stop");

  halt_ctrl_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    main_clock_halt_ctrl_bit |=> stabilization_status == shs_pkg::STATUS_ZERO)
    else $error("status not cleared by clock halt bit");

  clear_stays_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    status_clear && !hs_counting_reg && (state_reg != shs_pkg::SHS_STOP)
    |-> ##2 (stabilization_status == shs_pkg::STATUS_ZERO))
    else $error("status set again after a clear");

  status_order_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    (!status_reg[shs_pkg::POS_2P13] || status_reg[shs_pkg::POS_2P11]) &&
    (!status_reg[shs_pkg::POS_2P14] || status_reg[shs_pkg::POS_2P13]) &&
    (!status_reg[shs_pkg::POS_2P15] || status_reg[shs_pkg::POS_2P14]) &&
    (!status_reg[shs_pkg::POS_2P16] || status_reg[shs_pkg::POS_2P15]))
    else $error("status bits out of order");

  sel_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
    wait_sel_we |=> stabilization_wait_select == $past(wait_sel_wdata))
    else $error("wait select write lost");

  periph_live_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    !standby_active |-> periph_clk_sel == clk_sel.main_clock_select_bit)
    else $error("peripheral clock source not live while running");

endmodule : shs_standby_ctrl

// file: verif/shs_partner.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Oscillator model: ticks only while the design lets the oscillator run
// ---------------------------------------------------------------------------
module shs_partner (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Oscillator enables
  input  wire logic main_osc_run,
  input  wire logic int_osc_run,
  // Period ticks
  output logic      hs_clk_tick,
  output logic      int_osc_tick
);
  logic [1:0] div_reg;

  // Internal oscillator four times slower, so a short count is not hidden
  always_ff @(negedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_reg      <= 2'h0;
      hs_clk_tick  <= 1'b0;
      int_osc_tick <= 1'b0;
    end else begin
      div_reg      <= div_reg + 2'h1;
      hs_clk_tick  <= main_osc_run;
      int_osc_tick <= int_osc_run && (div_reg == 2'h0);
    end
  end
endmodule : shs_partner

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, resetn, halt, stp, irq, osc_off, clk_halt, iosc_off, opt, we;
  logic hs_t, int_t, cen, hold, sb, mrun, irun, psel;
  logic [2:0] wd, wsel;
  logic [4:0] stat;
  shs_pkg::shs_clk_sel_t sel;
  int fails, cmp_count, cyc;

  shs_standby_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .halt_insn_done(halt),
    .stop_insn_done(stp), .irq_pending_unmasked(irq), .cpu_clk_en(cen), .hold_state(hold),
    .standby_active(sb), .clk_sel(sel), .main_osc_stop_bit(osc_off),
    .main_clock_halt_ctrl_bit(clk_halt), .internal_osc_stop_bit(iosc_off),
    .opt_int_osc_stoppable(opt), .hs_clk_tick(hs_t), .int_osc_tick(int_t),
    .main_osc_run(mrun), .int_osc_run(irun), .periph_clk_sel(psel), .wait_sel_we(we),
    .wait_sel_wdata(wd), .stabilization_wait_select(wsel), .stabilization_status(stat));
  shs_partner i_osc (.clk_sys(clk_sys), .resetn(resetn), .main_osc_run(mrun),
    .int_osc_run(irun), .hs_clk_tick(hs_t), .int_osc_tick(int_t));

  // ---------------------------------------------------------------------------
  // Clock, watchdog, compare and report
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run is about 10500 cycles; ceiling leaves about twice that
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // Stimulus helpers, all at the falling edge
  // ---------------------------------------------------------------------------
  task automatic pulse_insn(input logic is_stop);
    @(negedge clk_sys);
    if (is_stop) stp = 1'b1;
    else halt = 1'b1;
    @(negedge clk_sys);
    stp  = 1'b0;
    halt = 1'b0;
  endtask : pulse_insn

  // Raise the wake request and count cycles until the CPU clock returns
  task automatic wake(output int n);
    n   = 0;
    irq = 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cen !== 1'b1 && n < 5000);
    irq = 1'b0;
  endtask : wake

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_halt();
    int n;
    sel = '{main_clock_select_bit: 1'b0, on_subsystem: 1'b0};
    // Converter and peripherals assumed stopped by software here
    pulse_insn(1'b0);
    chk("cen_halt", 17'h0, cen);
    chk("hold_halt", 17'h1, hold);
    chk("mrun_halt", 17'h1, mrun);
    sel = '{main_clock_select_bit: 1'b1, on_subsystem: 1'b0};
    @(negedge clk_sys);
    chk("psel_halt", 17'h0, psel);
    wake(n);
    chk("halt_wake", 17'h1, n);
  endtask : t_halt

  task automatic t_stop_hs();
    int n;
    @(negedge clk_sys);
    we = 1'b1;
    wd = shs_pkg::SEL_2P11;
    @(negedge clk_sys);
    we = 1'b0;
    chk("wsel", 17'h1, wsel);
    pulse_insn(1'b1);
    chk("mrun_stop", 17'h0, mrun);
    chk("stat_clr", 17'h0, stat);
    chk("cen_stop", 17'h0, cen);
    wake(n);
    chk("hs_wait", 17'h1, n >= 2048 && n <= 2054);
    @(negedge clk_sys);
    chk("stat_2p11", 17'h10, stat);
    clk_halt = 1'b1;
    @(negedge clk_sys);
    clk_halt = 1'b0;
    chk("stat_clk_halt", 17'h0, stat);
    repeat (4) @(negedge clk_sys);
    chk("stat_clear_held", 17'h0, stat);
  endtask : t_stop_hs

  task automatic t_stop_int();
    int n;
    sel = '{main_clock_select_bit: 1'b0, on_subsystem: 1'b0};
    we = 1'b1;
    wd = shs_pkg::SEL_2P13;
    @(negedge clk_sys);
    we = 1'b0;
    chk("wsel_2p13", 17'h2, wsel);
    pulse_insn(1'b1);
    chk("irun_stop", 17'h1, irun);
    chk("mrun_istop", 17'h0, mrun);
    wake(n);
    chk("int_wait", 17'h1, n >= 64 && n <= 72);
    // Count runs on after an internal-clock release, up to the selected wait
    repeat (2100) @(negedge clk_sys);
    chk("stat_int_short", 17'h10, stat);
    repeat (6100) @(negedge clk_sys);
    chk("stat_int_long", 17'h18, stat);
    @(negedge clk_sys);
    osc_off = 1'b1;
    @(negedge clk_sys);
    chk("stat_osc_off", 17'h0, stat);
    chk("mrun_osc_off", 17'h0, mrun);
    osc_off = 1'b0;
  endtask : t_stop_int

  task automatic t_misc();
    sel = '{main_clock_select_bit: 1'b1, on_subsystem: 1'b1};
    pulse_insn(1'b1);
    chk("sub_stop", 17'h0, sb);
    iosc_off = 1'b1;
    @(negedge clk_sys);
    chk("irun_locked", 17'h1, irun);
    opt = 1'b1;
    @(negedge clk_sys);
    chk("irun_free", 17'h0, irun);
    iosc_off = 1'b0;
  endtask : t_misc

  initial begin
    {resetn, halt, stp, irq, osc_off, clk_halt, iosc_off, opt, we} = 9'h000;
    wd = 3'h0;
    sel = '{main_clock_select_bit: 1'b1, on_subsystem: 1'b0};
    repeat (8) @(negedge clk_sys);
    chk("wsel_rst", 17'h5, wsel);
    chk("stat_rst", 17'h0, stat);
    resetn = 1'b1;
    @(negedge clk_sys);
    chk("cen_rst", 17'h1, cen);
    t_halt();
    t_stop_hs();
    t_stop_int();
    t_misc();
    summarize();
  end
endmodule : tb_top
